// ===== rtl/pmx_device.sv
// Device end: power states, wake-up and exception register.
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pmx_regs.svh"
module pmx_device
  import pmx_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  pmx_link_if.dev link,
  input wire logic i_uart_overflow,
  input wire logic i_radio_overflow,
  input wire logic i_reg_write_fail,
  input wire logic i_payload_crc_fail,
  input wire logic i_header_crc_fail,
  input wire logic i_sequence_mismatch,
  input wire logic i_frame_type_fail,
  input wire logic i_retry_event,
  input wire logic i_tx_done,
  input wire logic i_ram_ok,
  input wire logic i_compat_mode,
  input wire logic i_buffer_full,
  output logic o_ctrl_clk_slow,
  output logic o_ctrl_clk_stop,
  output logic o_radio_trx_on,
  output logic o_radio_osc_on,
  output logic o_factory_restore,
  output logic o_soft_reset,
  output logic [2:0] o_rf_rate_max,
  output logic [7:0] o_uart_baud
);
  function automatic logic [1:0] sync_step(input logic [1:0] s, input logic d);
    sync_step = {s[0], d};
  endfunction

  pmx_state_t state_reg, state_next;
  logic [1:0] rxd_s_reg, rst_s_reg, cmd_s_reg;
  logic [15:0] low_cnt_reg;
  logic [11:0] rstl_cnt_reg;
  logic [25:0] cmd_cnt_reg;
  logic [19:0] wake_cnt_reg;
  logic rst_armed_reg, cmd_armed_reg, cmd_lost_reg;
  logic [7:0] error_code_store_reg, error_mask_reg;
  logic [7:0] uart_baud_volatile_reg, uart_baud_saved_reg;
  logic [7:0] retry_limit_reg, retry_cnt_reg;
  logic wake_acknowledge_enable_reg, flag_reg;
  logic [7:0] rdata_reg;
  logic [3:0] ack_bit_reg;
  logic [15:0] ack_div_reg;
  logic txd_reg, soft_reset_reg, restore_reg;
  logic [7:0] new_code;
  logic [7:0] ack_shift;
  logic new_err, rd_err, wr_mode, rxd_wake, rst_wake, wake_done, retry_over;

  wire rxd_in = rxd_s_reg[1];
  wire rst_in = rst_s_reg[1];
  wire cmd_in = cmd_s_reg[1];
  assign wr_mode = link.reg_wr && link.reg_addr == `PMX_ADDR_MODE;
  assign rd_err = link.reg_rd && link.reg_addr == `PMX_ADDR_ERROR;
  assign retry_over = i_retry_event && (retry_cnt_reg >= retry_limit_reg);
  // Earlier sources in the chain win so a single code is stored per cycle.
  assign new_code = i_frame_type_fail ? `PMX_EX_FRAME_FAIL :
                    i_sequence_mismatch ? `PMX_EX_SEQ_FAIL :
                    i_header_crc_fail ? `PMX_EX_HEADER_CRC :
                    i_payload_crc_fail ? `PMX_EX_PAYLOAD_CRC :
                    retry_over ? `PMX_EX_MISSING_ACK :
                    i_reg_write_fail ? `PMX_EX_REG_FAIL :
                    i_radio_overflow ? `PMX_EX_RADIO_OVF :
                    i_uart_overflow ? `PMX_EX_UART_OVF : 8'h00;
  assign new_err = new_code != 8'h00;
  assign rxd_wake = low_cnt_reg >= `PMX_BIT_CYC;
  assign rst_wake = rst_armed_reg && rst_in;
  assign wake_done = wake_cnt_reg == `PMX_WAKE_CYC;
  assign ack_shift = `PMX_WAKE_ACK_BYTE >> (ack_bit_reg - 4'd1);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      PMX_RUN:
      begin
        if (wr_mode && link.reg_wdata == `PMX_MODE_STANDBY)
          state_next = PMX_STANDBY;
        else if (wr_mode && link.reg_wdata == `PMX_MODE_SLEEP)
          state_next = PMX_SLEEP;
        else if (wr_mode && link.reg_wdata == `PMX_MODE_DEEP)
          state_next = PMX_DEEP;
      end
      PMX_STANDBY, PMX_SLEEP:
        if (rxd_wake)
          state_next = PMX_WAKING;
      PMX_DEEP:
        if (rst_wake)
          state_next = PMX_WAKING;
      PMX_WAKING:
        if (wake_done)
          state_next = wake_acknowledge_enable_reg ? PMX_ACK : PMX_RUN;
      PMX_ACK:
        if (ack_bit_reg == 4'd10)
          state_next = PMX_RUN;
      default:
        state_next = PMX_RUN;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    rxd_s_reg <= sync_step(rxd_s_reg, link.host_txd);
    rst_s_reg <= sync_step(rst_s_reg, link.reset_n);
    cmd_s_reg <= sync_step(cmd_s_reg, link.cmd_n);
    if (!i_rstn)
    begin
      state_reg <= PMX_RUN;
      low_cnt_reg <= 16'h0000;
      rstl_cnt_reg <= 12'h000;
      rst_armed_reg <= 1'b0;
      wake_cnt_reg <= 20'h00000;
      cmd_cnt_reg <= 26'h0000000;
      cmd_armed_reg <= 1'b0;
      cmd_lost_reg <= 1'b0;
      restore_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      low_cnt_reg <= (!rxd_in && !rxd_wake) ? low_cnt_reg + 16'd1 :
                     (rxd_in ? 16'h0000 : low_cnt_reg);
      if (rst_in)
        rstl_cnt_reg <= 12'h000;
      else if (rstl_cnt_reg != `PMX_RST_LOW_CYC)
        rstl_cnt_reg <= rstl_cnt_reg + 12'd1;
      rst_armed_reg <= (state_reg == PMX_DEEP) &&
                       (rstl_cnt_reg == `PMX_RST_LOW_CYC || (rst_armed_reg && !rst_in));
      wake_cnt_reg <= (state_reg == PMX_WAKING) ? wake_cnt_reg + 20'd1 : 20'h00000;
      // Counting starts from reset release and stops for good once the line goes high.
      if (cmd_in)
        cmd_lost_reg <= 1'b1;
      if (!cmd_in && !cmd_lost_reg && cmd_cnt_reg != `PMX_FACTORY_CYC)
        cmd_cnt_reg <= cmd_cnt_reg + 26'd1;
      if (cmd_cnt_reg == `PMX_FACTORY_CYC && !cmd_in && !cmd_lost_reg)
        cmd_armed_reg <= 1'b1;
      restore_reg <= cmd_armed_reg && cmd_in;
      if (restore_reg)
        cmd_armed_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      error_code_store_reg <= 8'h00;
      flag_reg <= 1'b0;
      error_mask_reg <= `PMX_MASK_DEFAULT;
      uart_baud_volatile_reg <= `PMX_BAUD_DEFAULT;
      uart_baud_saved_reg <= `PMX_BAUD_DEFAULT;
      retry_limit_reg <= `PMX_RETRY_DEFAULT;
      retry_cnt_reg <= 8'h00;
      wake_acknowledge_enable_reg <= 1'b0;
      rdata_reg <= 8'h00;
      soft_reset_reg <= 1'b0;
    end
    else
    begin
      // A new error in the read cycle wins over the clear.
      if (new_err)
        error_code_store_reg <= new_code;
      else if (rd_err)
        error_code_store_reg <= 8'h00;
      if (new_err && (new_code & error_mask_reg) != 8'h00)
        flag_reg <= 1'b1;
      else if (rd_err)
        flag_reg <= 1'b0;
      retry_cnt_reg <= i_tx_done ? 8'h00 :
                       (i_retry_event ? retry_cnt_reg + 8'd1 : retry_cnt_reg);
      soft_reset_reg <= (state_reg == PMX_WAKING) && wake_done && !i_ram_ok;
      if (soft_reset_reg || restore_reg)
        uart_baud_volatile_reg <= uart_baud_saved_reg;
      else if (link.reg_wr && link.reg_addr == `PMX_ADDR_BAUD_VOL)
        uart_baud_volatile_reg <= link.reg_wdata;
      if (restore_reg)
      begin
        uart_baud_saved_reg <= `PMX_BAUD_DEFAULT;
        retry_limit_reg <= `PMX_RETRY_DEFAULT;
        error_mask_reg <= `PMX_MASK_DEFAULT;
        wake_acknowledge_enable_reg <= 1'b0;
      end
      else if (link.reg_wr)
      begin
        if (link.reg_addr == `PMX_ADDR_MASK)
          error_mask_reg <= link.reg_wdata;
        if (link.reg_addr == `PMX_ADDR_BAUD_SAVED)
          uart_baud_saved_reg <= link.reg_wdata;
        if (link.reg_addr == `PMX_ADDR_RETRY)
          retry_limit_reg <= link.reg_wdata;
        if (link.reg_addr == `PMX_ADDR_WAKE_ACK)
          wake_acknowledge_enable_reg <= link.reg_wdata[0];
      end
      case (link.reg_addr)
        `PMX_ADDR_MODE: rdata_reg <= {5'h00, state_reg};
        `PMX_ADDR_ERROR: rdata_reg <= error_code_store_reg;
        `PMX_ADDR_MASK: rdata_reg <= error_mask_reg;
        `PMX_ADDR_BAUD_VOL: rdata_reg <= uart_baud_volatile_reg;
        `PMX_ADDR_BAUD_SAVED: rdata_reg <= uart_baud_saved_reg;
        `PMX_ADDR_RETRY: rdata_reg <= retry_limit_reg;
        `PMX_ADDR_WAKE_ACK: rdata_reg <= {7'h00, wake_acknowledge_enable_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end
  end

  // Wake acknowledge: start bit, eight data bits LSB first, stop bit.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn || state_reg != PMX_ACK)
    begin
      ack_bit_reg <= 4'h0;
      ack_div_reg <= 16'h0000;
      txd_reg <= 1'b1;
    end
    else
    begin
      ack_div_reg <= (ack_div_reg == `PMX_BIT_CYC) ? 16'h0000 : ack_div_reg + 16'd1;
      if (ack_div_reg == `PMX_BIT_CYC)
        ack_bit_reg <= ack_bit_reg + 4'd1;
      txd_reg <= (ack_bit_reg == 4'd0) ? 1'b0 :
                 (ack_bit_reg >= 4'd9) ? 1'b1 :
                 ack_shift[0];
    end
  end

  assign link.dev_txd = txd_reg;
  assign link.reg_rdata = rdata_reg;
  assign link.error_flag_out = flag_reg;
  assign link.cts_n = (state_reg == PMX_DEEP) ? 1'b1 :
                      (state_reg == PMX_STANDBY || state_reg == PMX_SLEEP) ? 1'b0 :
                      (state_reg != PMX_RUN) || i_buffer_full;
  assign o_ctrl_clk_slow = state_reg == PMX_STANDBY || state_reg == PMX_SLEEP;
  assign o_ctrl_clk_stop = state_reg == PMX_DEEP;
  assign o_radio_trx_on = state_reg == PMX_RUN;
  assign o_radio_osc_on = state_reg != PMX_SLEEP && state_reg != PMX_DEEP;
  assign o_factory_restore = restore_reg;
  assign o_soft_reset = soft_reset_reg;
  assign o_rf_rate_max = i_compat_mode ? `PMX_RF_RATE_COMPAT : `PMX_RF_RATE_MAX;
  assign o_uart_baud = uart_baud_volatile_reg;
endmodule
`default_nettype wire

// ===== rtl/pmx_host.sv
// Host end: drives wake pulses, factory restore and register access.
`timescale 1ns/1ps
`default_nettype none
`include "pmx_regs.svh"
module pmx_host
  import pmx_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  pmx_link_if.host link,
  input wire logic i_wake_uart,
  input wire logic i_wake_reset,
  input wire logic i_factory_hold,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_busy,
  output logic o_cts_n,
  output logic o_error_flag,
  output logic o_dev_txd
);
  logic [15:0] rxd_cnt_reg;
  logic [11:0] rst_cnt_reg;
  logic [1:0] cts_s_reg, flag_s_reg, txd_s_reg;
  logic [7:0] rdata_reg;
  logic cmd_n_reg, wr_reg, rd_reg;
  logic [3:0] addr_reg;
  logic [7:0] wdata_reg;

  always_ff @(posedge i_clk)
  begin
    cts_s_reg <= {cts_s_reg[0], link.cts_n};
    flag_s_reg <= {flag_s_reg[0], link.error_flag_out};
    txd_s_reg <= {txd_s_reg[0], link.dev_txd};
    if (!i_rstn)
    begin
      rxd_cnt_reg <= 16'h0000;
      rst_cnt_reg <= 12'h000;
      cmd_n_reg <= 1'b1;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      addr_reg <= 4'h0;
      wdata_reg <= 8'h00;
      rdata_reg <= 8'h00;
    end
    else
    begin
      if (i_wake_uart && rxd_cnt_reg == 16'h0000)
        rxd_cnt_reg <= `PMX_BIT_CYC + 16'd1;
      else if (rxd_cnt_reg != 16'h0000)
        rxd_cnt_reg <= rxd_cnt_reg - 16'd1;
      if (i_wake_reset && rst_cnt_reg == 12'h000)
        rst_cnt_reg <= `PMX_RST_LOW_CYC + 12'd1;
      else if (rst_cnt_reg != 12'h000)
        rst_cnt_reg <= rst_cnt_reg - 12'd1;
      cmd_n_reg <= !i_factory_hold;
      wr_reg <= i_wr;
      rd_reg <= i_rd;
      addr_reg <= i_addr;
      wdata_reg <= i_wdata;
      rdata_reg <= link.reg_rdata;
    end
  end

  assign link.host_txd = rxd_cnt_reg == 16'h0000;
  assign link.reset_n = rst_cnt_reg == 12'h000;
  assign link.cmd_n = cmd_n_reg;
  assign link.reg_wr = wr_reg;
  assign link.reg_rd = rd_reg;
  assign link.reg_addr = addr_reg;
  assign link.reg_wdata = wdata_reg;
  assign o_rdata = rdata_reg;
  assign o_busy = rxd_cnt_reg != 16'h0000 || rst_cnt_reg != 12'h000;
  assign o_cts_n = cts_s_reg[1];
  assign o_error_flag = flag_s_reg[1];
  assign o_dev_txd = txd_s_reg[1];
endmodule
`default_nettype wire

// ===== rtl/pmx_link_if.sv
// Link between the radio module and its host controller.
`timescale 1ns/1ps
`default_nettype none
interface pmx_link_if;
  logic host_txd;
  logic dev_txd;
  logic cts_n;
  logic error_flag_out;
  logic reset_n;
  logic cmd_n;
  logic reg_wr;
  logic reg_rd;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  modport dev (
    input host_txd, reset_n, cmd_n, reg_wr, reg_rd, reg_addr, reg_wdata,
    output dev_txd, cts_n, error_flag_out, reg_rdata
  );
  modport host (
    output host_txd, reset_n, cmd_n, reg_wr, reg_rd, reg_addr, reg_wdata,
    input dev_txd, cts_n, error_flag_out, reg_rdata
  );
endinterface
`default_nettype wire

// ===== rtl/pmx_pkg.sv
// Types shared by both ends of the power mode and exception link.
`default_nettype none
package pmx_pkg;
  typedef enum logic [2:0] {
    PMX_RUN,
    PMX_STANDBY,
    PMX_SLEEP,
    PMX_DEEP,
    PMX_WAKING,
    PMX_ACK
  } pmx_state_t;
  typedef logic [7:0] pmx_byte_t;
endpackage
`default_nettype wire

// ===== rtl/pmx_regs.svh
// Constants for the power mode and exception controller.
`ifndef PMX_REGS_SVH
`define PMX_REGS_SVH
`define PMX_MODE_RUN 8'h00
`define PMX_MODE_SLEEP 8'h01
`define PMX_MODE_STANDBY 8'h02
`define PMX_MODE_DEEP 8'h03
`define PMX_EX_UART_OVF 8'h08
`define PMX_EX_RADIO_OVF 8'h09
`define PMX_EX_REG_FAIL 8'h13
`define PMX_EX_MISSING_ACK 8'h20
`define PMX_EX_PAYLOAD_CRC 8'h40
`define PMX_EX_HEADER_CRC 8'h42
`define PMX_EX_SEQ_FAIL 8'h43
`define PMX_EX_FRAME_FAIL 8'h44
`define PMX_WAKE_ACK_BYTE 8'h06
`define PMX_ADDR_MODE 4'h0
`define PMX_ADDR_ERROR 4'h1
`define PMX_ADDR_MASK 4'h2
`define PMX_ADDR_BAUD_VOL 4'h3
`define PMX_ADDR_BAUD_SAVED 4'h4
`define PMX_ADDR_CTRL 4'h5
`define PMX_ADDR_RETRY 4'h6
`define PMX_ADDR_STATUS 4'h7
`define PMX_ADDR_WAKE_ACK 4'h8
`define PMX_BAUD_DEFAULT 8'h03
`define PMX_RETRY_DEFAULT 8'h03
`define PMX_MASK_DEFAULT 8'hFF
`define PMX_CLK_NS 10
`define PMX_WAKE_NS 6000000
`define PMX_WAKE_CYC 20'd599000
`define PMX_RST_LOW_NS 20000
`define PMX_RST_LOW_CYC 12'd2000
`define PMX_FACTORY_NS 600000000
`define PMX_FACTORY_CYC 26'd60000000
`define PMX_BIT_CYC 16'd868
`define PMX_RF_RATE_MAX 3'd7
`define PMX_RF_RATE_COMPAT 3'd4
`endif

// ===== verif/pmx_link_chk.sv
// Concurrent checks on the link between the host end and the device end.
`timescale 1ns/1ps
`default_nettype none
`include "pmx_regs.svh"
module pmx_link_chk (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic host_txd,
  input wire logic dev_txd,
  input wire logic cts_n,
  input wire logic error_flag_out,
  input wire logic reset_n,
  input wire logic cmd_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  wire logic rd_code;
  wire logic wr_mode;
  logic low_reg;
  assign rd_code = reg_rd && (reg_addr == `PMX_ADDR_ERROR);
  assign wr_mode = reg_wr && (reg_addr == `PMX_ADDR_MODE) && !cts_n && !low_reg;
  // Tracks standby and sleep, where clear-to-send is low but mode writes are refused.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn || cts_n)
      low_reg <= 1'b0;
    else if (wr_mode && (reg_wdata == `PMX_MODE_SLEEP || reg_wdata == `PMX_MODE_STANDBY))
      low_reg <= 1'b1;
  end
  property wr_rd(a);
    reg_wr && reg_addr == a ##1 reg_rd && reg_addr == a |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  property mode_rb(m, s);
    wr_mode && reg_wdata == m ##1 reg_rd && reg_addr == `PMX_ADDR_MODE |=> reg_rdata == s;
  endproperty
  AST_FLAG_HOLD: assert property (error_flag_out && !rd_code |=> error_flag_out)
    else $error("Error flag dropped without a code read.");
  AST_FLAG_FALL: assert property ($fell(error_flag_out) |-> $past(rd_code))
    else $error("Error flag fell with no code read before it.");
  AST_FLAG_CODE: assert property (rd_code && error_flag_out |=> reg_rdata != 8'h00)
    else $error("Error flag was high but the stored code read zero.");
  AST_TXD_ACK: assert property (!dev_txd |-> cts_n)
    else $error("Transmit line active outside the acknowledge state.");
  AST_MASK_RB: assert property (wr_rd(`PMX_ADDR_MASK))
    else $error("Mask read back differs from the value written.");
  AST_BAUD_RB: assert property (wr_rd(`PMX_ADDR_BAUD_VOL))
    else $error("Volatile baud read back differs from the value written.");
  AST_MODE_STANDBY: assert property (mode_rb(`PMX_MODE_STANDBY, 8'h01))
    else $error("Standby request did not reach the standby state.");
  AST_MODE_SLEEP: assert property (mode_rb(`PMX_MODE_SLEEP, 8'h02))
    else $error("Sleep request did not reach the sleep state.");
  AST_MODE_DEEP: assert property (mode_rb(`PMX_MODE_DEEP, 8'h03))
    else $error("Deep sleep request did not reach the deep sleep state.");
  AST_DEEP_CTS: assert property (wr_mode && reg_wdata == `PMX_MODE_DEEP |=> cts_n [*4])
    else $error("Clear to send not high in deep sleep.");
  cover property (rd_code && error_flag_out);
  cover property ($rose(reset_n));
  cover property ($fell(host_txd));
endmodule
`default_nettype wire

// ===== verif/test_power_mode_exception_ctrl.sv
// Self-checking testbench for the host and device ends of the link.
`timescale 1ns/1ps
`default_nettype none
`include "pmx_regs.svh"
module test_power_mode_exception_ctrl;
  import pmx_pkg::*;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic wake_u = 1'b0;
  logic wake_r = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic [6:0] err = 7'h00;
  logic retry = 1'b0;
  logic compat = 1'b0;
  logic bfull = 1'b0;
  logic done = 1'b0;
  logic [7:0] h_rdata;
  logic h_busy, h_cts, h_flag, h_txd, f_restore, s_reset;
  logic slow, stop, trx, osc;
  logic [2:0] rate;
  logic [7:0] baud;
  int failures = 0;
  int n_checks = 0;
  localparam logic [7:0] CODES [7] = '{`PMX_EX_UART_OVF, `PMX_EX_RADIO_OVF, `PMX_EX_REG_FAIL,
    `PMX_EX_PAYLOAD_CRC, `PMX_EX_HEADER_CRC, `PMX_EX_SEQ_FAIL, `PMX_EX_FRAME_FAIL};
  localparam logic [7:0] MASKS [6] = '{8'h08, 8'h10, 8'h20, 8'h40, 8'h60, 8'h00};
  pmx_link_if link ();
  pmx_device pmx_device_i (.i_clk(i_clk), .i_rstn(i_rstn), .link(link),
    .i_uart_overflow(err[0]), .i_radio_overflow(err[1]), .i_reg_write_fail(err[2]),
    .i_payload_crc_fail(err[3]), .i_header_crc_fail(err[4]), .i_sequence_mismatch(err[5]),
    .i_frame_type_fail(err[6]), .i_retry_event(retry), .i_tx_done(done), .i_ram_ok(1'b1),
    .i_compat_mode(compat), .i_buffer_full(bfull), .o_ctrl_clk_slow(slow),
    .o_ctrl_clk_stop(stop), .o_radio_trx_on(trx), .o_radio_osc_on(osc),
    .o_factory_restore(f_restore), .o_soft_reset(s_reset), .o_rf_rate_max(rate),
    .o_uart_baud(baud));
  pmx_host pmx_host_i (.i_clk(i_clk), .i_rstn(i_rstn), .link(link), .i_wake_uart(wake_u),
    .i_wake_reset(wake_r), .i_factory_hold(1'b0), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
    .i_wdata(i_wdata), .o_rdata(h_rdata), .o_busy(h_busy), .o_cts_n(h_cts),
    .o_error_flag(h_flag), .o_dev_txd(h_txd));
  pmx_link_chk pmx_link_chk_i (.i_clk(i_clk), .i_rstn(i_rstn), .host_txd(link.host_txd),
    .dev_txd(link.dev_txd), .cts_n(link.cts_n), .error_flag_out(link.error_flag_out),
    .reset_n(link.reset_n), .cmd_n(link.cmd_n), .reg_wr(link.reg_wr), .reg_rd(link.reg_rd),
    .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata));
  always #5 i_clk = ~i_clk;
  function automatic logic [7:0] exp_state(input int m);
    exp_state = (m == 1) ? 8'h02 : (m == 2) ? 8'h01 : 8'h03;
  endfunction
  function automatic logic exp_flag(input logic [7:0] c, input logic [7:0] k);
    exp_flag = (c & k) != 8'h00;
  endfunction
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    tick(1);
    i_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    int k;
    i_rd <= 1'b1;
    i_addr <= a;
    tick(1);
    i_rd <= 1'b0;
    #1;
    for (k = 0; k < 8 && link.reg_rd !== 1'b1; k++)
    begin
      tick(1);
      #1;
    end
    if (k == 8)
    begin
      failures++;
      summarize();
    end
    tick(1);
    #1;
    d = link.reg_rdata;
    tick(1);
  endtask
  task automatic rst();
    i_rstn <= 1'b0;
    tick(3);
    i_rstn <= 1'b1;
    tick(1);
  endtask
  initial
  begin
    repeat (100000) @(posedge i_clk);
    failures++;
    summarize();
  end
  initial
  begin
    logic [7:0] d, exp, mask, st;
    logic flg;
    int idx, k;
    idx = $urandom(66567);
    tick(20);
    i_rstn <= 1'b1;
    tick(1);
    rd_reg(`PMX_ADDR_MASK, d);
    cmp8(d, `PMX_MASK_DEFAULT, "mask reset");
    compat <= 1'b1;
    bfull <= 1'b1;
    tick(2);
    cmp8({5'h00, rate}, 8'h04, "compat rate");
    cmp8({7'h00, link.cts_n}, 8'h01, "cts with full buffer");
    compat <= 1'b0;
    bfull <= 1'b0;
    tick(2);
    cmp8({5'h00, rate}, 8'h07, "normal rate");
    cmp8({7'h00, link.cts_n}, 8'h00, "cts with room");
    wr_reg(`PMX_ADDR_BAUD_VOL, 8'h05);
    rd_reg(`PMX_ADDR_BAUD_VOL, d);
    cmp8(d, 8'h05, "baud readback");
    cmp8(baud, 8'h05, "baud output");
    for (int m = 1; m < 4; m++)
    begin
      st = exp_state(m);
      wr_reg(`PMX_ADDR_MODE, 8'(m));
      rd_reg(`PMX_ADDR_MODE, d);
      cmp8(d, st, "mode state");
      cmp8({link.cts_n, slow, stop, trx, osc}, {m == 3, m != 3, m == 3, 1'b0, m == 2}, "pins");
      if (m == 3)
      begin
        wake_r <= 1'b1;
        tick(1);
        wake_r <= 1'b0;
        tick(1000);
        cmp8({7'h00, h_busy}, 8'h01, "host holding reset low");
        rd_reg(`PMX_ADDR_MODE, d);
        cmp8(d, 8'h03, "asleep while reset low");
        for (k = 0; k < 1500 && link.reset_n !== 1'b1; k++)
          tick(1);
        if (k == 1500)
        begin
          failures++;
          summarize();
        end
        tick(3);
      end
      else
      begin
        wake_u <= 1'b1;
        tick(1);
        wake_u <= 1'b0;
        tick(500);
        cmp8({7'h00, h_busy}, 8'h01, "host holding receive low");
        rd_reg(`PMX_ADDR_MODE, d);
        cmp8(d, st, "asleep during short pulse");
        tick(500);
      end
      rd_reg(`PMX_ADDR_MODE, d);
      cmp8(d, 8'h04, "waking");
      cmp8({6'h00, h_cts, link.cts_n}, 8'h03, "cts while waking");
      cmp8({4'h0, h_busy, h_txd, s_reset, f_restore}, 8'h04, "idle lines while waking");
      rst();
    end
    for (int t = 0; t < 30; t++)
    begin
      mask = (t < 6) ? MASKS[t] : 8'($urandom);
      wr_reg(`PMX_ADDR_MASK, mask);
      rd_reg(`PMX_ADDR_MASK, d);
      cmp8(d, mask, "mask");
      flg = 1'b0;
      for (int j = 0; j < 1 + (t % 3 == 0); j++)
      begin
        idx = (t < 7) ? t : $urandom_range(6, 0);
        exp = CODES[idx];
        flg = flg | exp_flag(exp, mask);
        err <= 7'h01 << idx;
        tick(1);
      end
      err <= 7'h00;
      tick(3);
      cmp8({6'h00, h_flag, link.error_flag_out}, {6'h00, flg, flg}, "flag");
      cmp8(h_rdata, mask, "host read data");
      rd_reg(`PMX_ADDR_ERROR, d);
      cmp8(d, exp, "code");
      cmp8({7'h00, link.error_flag_out}, 8'h00, "flag after read");
      rd_reg(`PMX_ADDR_ERROR, d);
      cmp8(d, 8'h00, "code after read");
      cmp8({7'h00, h_flag}, 8'h00, "host flag after read");
    end
    wr_reg(`PMX_ADDR_RETRY, 8'h02);
    for (int j = 0; j < 3; j++)
    begin
      retry <= 1'b1;
      tick(1);
      retry <= 1'b0;
      tick(2);
      rd_reg(`PMX_ADDR_ERROR, d);
      cmp8(d, (j == 2) ? `PMX_EX_MISSING_ACK : 8'h00, "retry limit");
    end
    done <= 1'b1;
    tick(1);
    done <= 1'b0;
    retry <= 1'b1;
    tick(1);
    retry <= 1'b0;
    tick(2);
    rd_reg(`PMX_ADDR_ERROR, d);
    cmp8(d, 8'h00, "retry count cleared");
    summarize();
  end
endmodule
`default_nettype wire
